// [bench/gdi_ctl_model.sv]
// Bus controller model that sends commands and data and accepts talker bytes.
`timescale 1ns/10ps
module gdi_ctl_model (
  input wire logic clk_i,
  input wire logic nrfd_i,
  input wire logic ndac_i,
  input wire logic dav_i,
  input wire logic [7:0] dio_i,
  output logic atn_n_o = 1'b1,
  output logic dav_n_o = 1'b1,
  output logic [7:0] dio_n_o = 8'hFF,
  output logic nrfd_n_o = 1'b1,
  output logic ndac_n_o = 1'b1,
  output logic ren_n_o = 1'b1,
  output logic ifc_n_o = 1'b1
);
  int n_to = 0;
  task automatic wait_for(input int s, input logic v);
    int k;
    k = 0;
    while (((s == 0) ? nrfd_i : (s == 1) ? ndac_i : dav_i) !== v && k < 300) begin
      @(negedge clk_i);
      k++;
    end
    if (k == 300) n_to++;
  endtask : wait_for
  task automatic send(input logic cmd, input logic [7:0] b);
    @(negedge clk_i);
    atn_n_o = ~cmd;
    nrfd_n_o = 1'b1;
    ndac_n_o = 1'b1;
    dio_n_o = ~b;
    @(negedge clk_i);
    wait_for(0, 1'b1);
    @(negedge clk_i);
    dav_n_o = 1'b0;
    wait_for(1, 1'b1);
    dav_n_o = 1'b1;
    dio_n_o = 8'hFF;
    wait_for(1, 1'b0);
  endtask : send
  task automatic recv(output logic [7:0] b);
    @(negedge clk_i);
    atn_n_o = 1'b1;
    ndac_n_o = 1'b0;
    nrfd_n_o = 1'b1;
    wait_for(2, 1'b0);
    b = ~dio_i;
    nrfd_n_o = 1'b0;
    ndac_n_o = 1'b1;
    wait_for(2, 1'b1);
    ndac_n_o = 1'b0;
  endtask : recv
  task automatic set_ren(input logic v);
    @(negedge clk_i);
    ren_n_o = v;
  endtask : set_ren
  task automatic pulse_ifc();
    @(negedge clk_i);
    ifc_n_o = 1'b0;
    repeat (4) @(negedge clk_i);
    ifc_n_o = 1'b1;
  endtask : pulse_ifc
endmodule : gdi_ctl_model

// [bench/gdi_port_checker.sv]
// Assertion checker bound to the instrument bus device port.
`timescale 1ns/10ps
module gdi_port_checker import gdi_pkg::*; #(
  parameter int SETTLE_CYC = 2
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic kbd_lock_i,
  input wire logic ren_n_i,
  input wire logic ifc_n_i,
  input wire logic instr_cmd_i,
  input wire logic dio_n_oe_o,
  input wire logic dav_n_oe_o,
  input wire logic srq_n_oe_o,
  input wire logic [7:0] serial_poll_status_byte_o,
  input wire gdi_clr_s clear_o,
  input wire logic trigger_enable_o,
  input wire logic trigger_o,
  input wire logic remote_o,
  input wire logic keyboard_enable_o,
  input wire logic lacs_o,
  input wire logic tacs_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////
  property p_srq; srq_n_oe_o == serial_poll_status_byte_o[6]; endproperty
  a_srq: assert property (p_srq) else $error("srq line differs from bit 6");
  property p_srq_drop;
    $fell(srq_n_oe_o) |-> clear_o.out_flush || $past(dav_n_oe_o);
  endproperty
  a_srq_drop: assert property (p_srq_drop) else $error("srq dropped without poll");
  property p_settle; $rose(dio_n_oe_o) |-> ##SETTLE_CYC $rose(dav_n_oe_o); endproperty
  a_settle: assert property (p_settle) else $error("data valid timing wrong");
  property p_trig; trigger_o |-> $past(trigger_enable_o); endproperty
  a_trig: assert property (p_trig) else $error("trigger while disabled");
  property p_clr; clear_o.out_flush |-> clear_o == 4'hF; endproperty
  a_clr: assert property (p_clr) else $error("clear pulses split");
  property p_clr_trig; clear_o.out_flush && !instr_cmd_i |=> !trigger_enable_o; endproperty
  a_clr_trig: assert property (p_clr_trig) else $error("clear left trigger on");
  property p_kbd; kbd_lock_i && $past(kbd_lock_i) |-> !keyboard_enable_o; endproperty
  a_kbd: assert property (p_kbd) else $error("keyboard on while locked");
  property p_rem; $rose(remote_o) |-> !$past(ren_n_i); endproperty
  a_rem: assert property (p_rem) else $error("remote without enable");
  property p_ifc; !ifc_n_i [*3] |-> !lacs_o && !tacs_o; endproperty
  a_ifc: assert property (p_ifc) else $error("addressed during clear");
  c_trig: cover property (trigger_o);
  c_rem: cover property ($rose(remote_o));
  c_clr: cover property (clear_o.out_flush);
endmodule : gdi_port_checker

bind gdi_device_port gdi_port_checker #(.SETTLE_CYC(SETTLE_CYC)) gdi_port_checker_i (.*);

// [bench/tb.sv]
// Self-checking testbench for the instrument bus device port.
`timescale 1ns/10ps
module tb;
  import gdi_pkg::*;
  localparam logic [7:0] MLA = 8'h36;
  localparam logic [7:0] MTA = 8'h56;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce_i = 1'b1;
  logic [4:0] my_addr_i = 5'h16;
  logic tx_valid_i = 1'b0, rx_ready_i = 1'b1, ready_i = 1'b1, sub_running_i = 1'b0;
  logic sub_paused_i = 1'b0, kbd_lock_i = 1'b0;
  logic [7:0] status_event_i = 8'h00, status_cause_i = 8'h00;
  gdi_byte_s tx_i = '0;
  logic [3:0] pl = 4'h0;
  logic instr_cmd_i, trigger_arm_command_i, single_trigger_command_i, status_byte_query_i;
  logic [7:0] dio_n_i, dio_n_o, c_dio, status_replace_data_o, serial_poll_status_byte_o;
  logic dio_n_oe_o, dav_n_i, dav_n_o, dav_n_oe_o, nrfd_n_i, nrfd_n_o, nrfd_n_oe_o;
  logic ndac_n_i, ndac_n_o, ndac_n_oe_o, eoi_n_i, eoi_n_o, eoi_n_oe_o, atn_n_i;
  logic ifc_n_i, ren_n_i, srq_n_o, srq_n_oe_o, tx_ready_o, rx_valid_o, status_replace_o;
  logic trigger_enable_o, trigger_o, sub_resume_o, remote_o, keyboard_enable_o;
  logic local_key_enable_o, lacs_o, tacs_o, c_dav, c_nrfd, c_ndac;
  gdi_byte_s rx_o;
  gdi_clr_s clear_o;
  logic [7:0] n_trig = 8'h00, n_res = 8'h00, n_clr = 8'h00, last_rx = 8'h00, rep = 8'h00;
  logic [7:0] n_txr = 8'h00;
  int mismatches = 0;
  int n_compared = 0;
  assign {instr_cmd_i, trigger_arm_command_i, single_trigger_command_i, status_byte_query_i} = pl;
  assign dio_n_i = (dio_n_oe_o ? dio_n_o : 8'hFF) & c_dio;
  assign dav_n_i = (dav_n_oe_o ? dav_n_o : 1'b1) & c_dav;
  assign nrfd_n_i = (nrfd_n_oe_o ? nrfd_n_o : 1'b1) & c_nrfd;
  assign ndac_n_i = (ndac_n_oe_o ? ndac_n_o : 1'b1) & c_ndac;
  assign eoi_n_i = eoi_n_oe_o ? eoi_n_o : 1'b1;
  always #2 clk_i = ~clk_i;
  gdi_device_port #(.SETTLE_CYC(2)) gdi_device_port_i (.*);
  gdi_ctl_model gdi_ctl_model_i (.clk_i(clk_i), .nrfd_i(nrfd_n_i), .ndac_i(ndac_n_i),
    .dav_i(dav_n_i), .dio_i(dio_n_i), .atn_n_o(atn_n_i), .dav_n_o(c_dav), .dio_n_o(c_dio),
    .nrfd_n_o(c_nrfd), .ndac_n_o(c_ndac), .ren_n_o(ren_n_i), .ifc_n_o(ifc_n_i));
  always @(posedge clk_i) begin
    if (rx_valid_o) last_rx <= rx_o.data;
    if (trigger_o) n_trig <= n_trig + 8'h01;
    if (sub_resume_o) n_res <= n_res + 8'h01;
    if (clear_o.out_flush) n_clr <= n_clr + 8'h01;
    if (status_replace_o) rep <= status_replace_data_o;
    if (tx_ready_o) n_txr <= n_txr + 8'h01;
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tick
  task automatic pulse(input logic [3:0] m);
    @(negedge clk_i);
    pl = m;
    @(negedge clk_i);
    pl = 4'h0;
  endtask : pulse
  task automatic t_remote();
    gdi_ctl_model_i.send(1'b1, MLA);
    tick(4);
    chk("remote no ren", 8'h00, 8'(remote_o));
    gdi_ctl_model_i.set_ren(1'b0);
    tick(4);
    chk("remote ren only", 8'h00, 8'(remote_o));
    gdi_ctl_model_i.send(1'b1, MLA);
    tick(4);
    chk("remote", 8'h01, 8'(remote_o));
    gdi_ctl_model_i.send(1'b0, 8'hA5);
    chk("rx data", 8'hA5, last_rx);
  endtask : t_remote
  task automatic t_lock();
    gdi_ctl_model_i.send(1'b1, 8'h11);
    tick(4);
    chk("lockout", 8'h00, 8'({keyboard_enable_o, local_key_enable_o}));
    gdi_ctl_model_i.send(1'b1, 8'h01);
    tick(4);
    chk("go local", 8'h01, 8'({remote_o, keyboard_enable_o}));
    gdi_ctl_model_i.send(1'b1, MLA);
    tick(4);
    chk("relock", 8'h02, 8'({remote_o, keyboard_enable_o}));
    kbd_lock_i = 1'b1;
    gdi_ctl_model_i.set_ren(1'b1);
    tick(4);
    chk("lock held", 8'h00, 8'({remote_o, keyboard_enable_o}));
    kbd_lock_i = 1'b0;
    tick(4);
    chk("ren drop", 8'h01, 8'({remote_o, keyboard_enable_o}));
    gdi_ctl_model_i.set_ren(1'b0);
  endtask : t_lock
  task automatic t_clear();
    gdi_ctl_model_i.send(1'b1, MLA);
    status_cause_i = 8'h20;
    @(negedge clk_i);
    status_event_i = 8'h22;
    @(negedge clk_i);
    status_event_i = 8'h00;
    tick(2);
    chk("srq on", 8'h01, 8'(srq_n_oe_o));
    gdi_ctl_model_i.send(1'b1, 8'h04);
    tick(4);
    chk("clear count", 8'h01, n_clr);
    chk("clear status", 8'h70, serial_poll_status_byte_o);
    chk("trig off", 8'h00, 8'(trigger_enable_o));
    pulse(4'h2);
    tick(2);
    chk("no trig", 8'h00, n_trig);
    gdi_ctl_model_i.send(1'b1, 8'h14);
    tick(4);
    chk("dcl count", 8'h02, n_clr);
    status_cause_i = 8'h00;
    pulse(4'h8);
    tick(2);
    chk("trig back", 8'h01, 8'(trigger_enable_o));
  endtask : t_clear
  task automatic t_trig();
    pulse(4'h4);
    gdi_ctl_model_i.send(1'b1, 8'h08);
    tick(4);
    chk("get once", 8'h01, n_trig);
    gdi_ctl_model_i.send(1'b1, 8'h08);
    tick(4);
    chk("get held", 8'h01, n_trig);
    sub_paused_i = 1'b1;
    pulse(4'h4);
    gdi_ctl_model_i.send(1'b1, 8'h08);
    tick(4);
    chk("resume", 8'h11, {n_res[3:0], n_trig[3:0]});
    sub_paused_i = 1'b0;
  endtask : t_trig
  task automatic t_poll();
    logic [7:0] b;
    sub_running_i = 1'b1;
    tick(3);
    chk("busy bit", 8'h60, serial_poll_status_byte_o);
    sub_running_i = 1'b0;
    pulse(4'h1);
    tick(2);
    chk("query", 8'h60, rep);
    gdi_ctl_model_i.send(1'b1, 8'h18);
    gdi_ctl_model_i.send(1'b1, MTA);
    gdi_ctl_model_i.recv(b);
    chk("poll byte", 8'h70, b);
    chk("poll keeps out", 8'h00, n_txr);
    gdi_ctl_model_i.send(1'b1, 8'h19);
    tick(4);
    chk("after poll", 8'h10, serial_poll_status_byte_o);
    chk("srq off", 8'h00, 8'(srq_n_oe_o));
  endtask : t_poll
  task automatic t_talk();
    logic [7:0] b;
    tx_i = {8'hC3, 1'b1};
    tx_valid_i = 1'b1;
    gdi_ctl_model_i.send(1'b1, MTA);
    gdi_ctl_model_i.recv(b);
    tx_valid_i = 1'b0;
    chk("talk byte", 8'hC3, b);
    chk("talk eoi", 8'h01, 8'(eoi_n_oe_o));
    chk("talk taken", 8'h01, n_txr);
    gdi_ctl_model_i.send(1'b1, 8'h5F);
    gdi_ctl_model_i.send(1'b1, 8'h3F);
    chk("unaddress", 8'h00, 8'({lacs_o, tacs_o}));
    gdi_ctl_model_i.send(1'b1, MLA);
    gdi_ctl_model_i.send(1'b1, MTA);
    gdi_ctl_model_i.pulse_ifc();
    tick(2);
    chk("ifc", 8'h00, 8'({lacs_o, tacs_o}));
  endtask : t_talk
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    t_remote();
    t_lock();
    t_clear();
    t_trig();
    t_poll();
    t_talk();
    chk("timeouts", 8'h00, gdi_ctl_model_i.n_to[7:0]);
    tally_and_finish();
  end
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
endmodule : tb

// [core/gdi_device_port.sv]
// Device side of the instrument bus port: handshakes, addressing, status and control.
// How it works
// - Full source and acceptor three-wire handshakes.
// - Talk when addressed; serial poll returns status.
// - Accept data bytes when addressed to listen.
// - Service request line independent of transfers.
// - Remote or front panel control by state.
// - Universal or selected clear resets device.
// - Addressed group trigger requests a measurement.
// - Interface clear returns bus logic to idle.
// - Clear flushes buffers, aborts, blanks, disables triggering.
// - Clear empties status except persisting bits 4-6.
// - Next instrument command restores trigger mode.
// - Go-to-local leaves remote when addressed to listen, lockout or not.
// - Lockout local lasts until next remote; REN drop permanent.
// - Lockout: local stays local, remote locks keyboard.
// - Lockout released only by REN drop or power.
// - Keyboard enabled only when local and keyboard lock input clear.
// - Remote needs REN plus own listen address.
// - Status byte bit layout fixed, bit 7 data.
// - Poll with request clears gone causes only.
// - Poll returns status without disturbing the processor.
// - Poll keeps output data; query replaces it.
// - Armed trigger fires once then holds.
// - Paused subprogram resumes instead of triggering.
// - Ready bit low while subprogram runs.
`timescale 1ns/10ps
`include "gdi_defines.svh"

module gdi_device_port import gdi_pkg::*; #(
  parameter int SETTLE_CYC = `GDI_SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [4:0] my_addr_i,
  input wire logic [7:0] dio_n_i,
  output logic [7:0] dio_n_o,
  output logic dio_n_oe_o,
  input wire logic dav_n_i,
  output logic dav_n_o,
  output logic dav_n_oe_o,
  input wire logic nrfd_n_i,
  output logic nrfd_n_o,
  output logic nrfd_n_oe_o,
  input wire logic ndac_n_i,
  output logic ndac_n_o,
  output logic ndac_n_oe_o,
  input wire logic eoi_n_i,
  output logic eoi_n_o,
  output logic eoi_n_oe_o,
  input wire logic atn_n_i,
  input wire logic ifc_n_i,
  input wire logic ren_n_i,
  output logic srq_n_o,
  output logic srq_n_oe_o,
  input wire logic tx_valid_i,
  input wire gdi_byte_s tx_i,
  output logic tx_ready_o,
  input wire logic rx_ready_i,
  output logic rx_valid_o,
  output gdi_byte_s rx_o,
  input wire logic [7:0] status_event_i,
  input wire logic [7:0] status_cause_i,
  input wire logic ready_i,
  input wire logic sub_running_i,
  input wire logic sub_paused_i,
  input wire logic kbd_lock_i,
  input wire logic instr_cmd_i,
  input wire logic trigger_arm_command_i,
  input wire logic single_trigger_command_i,
  input wire logic status_byte_query_i,
  output logic [7:0] serial_poll_status_byte_o,
  output logic status_replace_o,
  output logic [7:0] status_replace_data_o,
  output gdi_clr_s clear_o,
  output logic trigger_enable_o,
  output logic trigger_o,
  output logic sub_resume_o,
  output logic remote_o,
  output logic keyboard_enable_o,
  output logic local_key_enable_o,
  output logic lacs_o,
  output logic tacs_o
);

  generate
    if (SETTLE_CYC < 1) begin : g_bad
      $error("gdi_device_port: SETTLE_CYC must be at least one cycle.");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////

  // Bus lines are active low; internal names use asserted-high levels.
  logic atn_as;
  logic ifc_as;
  logic ren_as;
  logic dav_as;
  logic nrfd_as;
  logic ndac_as;
  logic [7:0] dio_as;

  assign atn_as = !atn_n_i;
  assign ifc_as = !ifc_n_i;
  assign ren_as = !ren_n_i;
  assign dav_as = !dav_n_i;
  assign nrfd_as = !nrfd_n_i;
  assign ndac_as = !ndac_n_i;
  assign dio_as = ~dio_n_i;

  gdi_ah_e ah_state;
  gdi_rl_e rl_state;
  logic lacs;
  logic tacs;
  logic spms;
  logic ah_active;
  logic ah_ready;
  logic acc_take;
  logic cmd_take;
  logic [6:0] cmd;
  logic [7:0] stb;
  logic [7:0] cause;
  logic [7:0] next_stb;
  logic trig_armed;
  logic trig_off;
  logic dev_clear;
  logic sp_sent;
  logic src_en;
  logic src_valid;
  logic src_taken;
  logic src_dav;
  logic src_drive;
  gdi_byte_s src_byte;
  gdi_byte_s src_out;

  //////////////////////////////////////////////////////////////////////////////

  // Acceptor takes commands while ATN is asserted and data while listening.
  assign ah_active = atn_as || lacs;
  assign ah_ready = atn_as || rx_ready_i;
  assign acc_take = ce_i && ah_active && (ah_state == AH_WAIT) && dav_as && ah_ready;

  always_ff @(posedge clk_i) begin
    if (reset_i || ifc_as) begin
      ah_state <= AH_WAIT;
    end else if (ce_i) begin
      if (!ah_active) begin
        ah_state <= AH_WAIT;
      end else begin
        unique case (ah_state)
          AH_WAIT: begin
            if (dav_as && ah_ready) begin
              ah_state <= AH_HOLD;
            end
          end
          AH_HOLD: begin
            if (!dav_as) begin
              ah_state <= AH_WAIT;
            end
          end
        endcase
      end
    end
  end

  assign nrfd_n_o = 1'b0;
  assign ndac_n_o = 1'b0;
  assign nrfd_n_oe_o = ah_active && ((ah_state == AH_HOLD) || !ah_ready);
  assign ndac_n_oe_o = ah_active && (ah_state == AH_WAIT);

  // Accepted bytes: commands go to the decoder, data goes to the input path.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmd_take <= 1'b0;
      cmd <= '0;
      rx_valid_o <= 1'b0;
      rx_o <= '0;
    end else if (ce_i) begin
      cmd_take <= acc_take && atn_as;
      rx_valid_o <= acc_take && !atn_as && lacs;
      if (acc_take && atn_as) begin
        cmd <= dio_as[6:0];
      end
      if (acc_take && !atn_as) begin
        rx_o <= '{data: dio_as, eoi: !eoi_n_i};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Listen, talk and serial poll mode addressing.
  always_ff @(posedge clk_i) begin
    if (reset_i || ifc_as) begin
      lacs <= 1'b0;
      tacs <= 1'b0;
      spms <= 1'b0;
    end else if (ce_i && cmd_take) begin
      if (cmd == {`GDI_GRP_LISTEN, my_addr_i}) begin
        lacs <= 1'b1;
      end else if (cmd == `GDI_CMD_UNL) begin
        lacs <= 1'b0;
      end
      if (cmd[6:5] == `GDI_GRP_TALK) begin
        tacs <= (cmd[4:0] == my_addr_i);
      end
      if (cmd == `GDI_CMD_SPE) begin
        spms <= 1'b1;
      end else if (cmd == `GDI_CMD_SPD) begin
        spms <= 1'b0;
      end
    end
  end

  assign lacs_o = lacs;
  assign tacs_o = tacs;

  //////////////////////////////////////////////////////////////////////////////

  // Talker: status byte in serial poll mode, otherwise the output buffer.
  assign src_en = tacs && !atn_as;
  assign src_valid = spms || tx_valid_i;
  assign src_byte = spms ? gdi_byte_s'{data: stb, eoi: 1'b0} : tx_i;
  assign tx_ready_o = src_taken && !spms;
  assign sp_sent = src_taken && spms;

  gdi_src_hs #(
    .SETTLE_CYC(SETTLE_CYC)
  ) u_src (
    .clk_i(clk_i),
    .reset_i(reset_i || ifc_as),
    .ce_i(ce_i),
    .enable_i(src_en),
    .valid_i(src_valid),
    .byte_i(src_byte),
    .nrfd_as_i(nrfd_as),
    .ndac_as_i(ndac_as),
    .taken_o(src_taken),
    .dav_as_o(src_dav),
    .drive_o(src_drive),
    .byte_o(src_out)
  );

  assign dio_n_o = ~src_out.data;
  assign dio_n_oe_o = src_drive;
  assign dav_n_o = 1'b0;
  assign dav_n_oe_o = src_dav;
  assign eoi_n_o = 1'b0;
  assign eoi_n_oe_o = src_drive && src_out.eoi;

  //////////////////////////////////////////////////////////////////////////////

  // Remote and local state with lockout.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rl_state <= RL_LOCAL;
    end else if (ce_i) begin
      if (!ren_as) begin
        rl_state <= RL_LOCAL;
      end else if (cmd_take) begin
        unique case (rl_state)
          RL_LOCAL: begin
            if (cmd == {`GDI_GRP_LISTEN, my_addr_i}) begin
              rl_state <= RL_REMOTE;
            end else if (cmd == `GDI_CMD_LLO) begin
              rl_state <= RL_LOCAL_LOCK;
            end
          end
          RL_REMOTE: begin
            if (cmd == `GDI_CMD_GTL && lacs) begin
              rl_state <= RL_LOCAL;
            end else if (cmd == `GDI_CMD_LLO) begin
              rl_state <= RL_REMOTE_LOCK;
            end
          end
          RL_LOCAL_LOCK: begin
            if (cmd == {`GDI_GRP_LISTEN, my_addr_i}) begin
              rl_state <= RL_REMOTE_LOCK;
            end
          end
          RL_REMOTE_LOCK: begin
            if (cmd == `GDI_CMD_GTL && lacs) begin
              rl_state <= RL_LOCAL_LOCK;
            end
          end
        endcase
      end
    end
  end

  assign remote_o = (rl_state == RL_REMOTE) || (rl_state == RL_REMOTE_LOCK);
  assign keyboard_enable_o = !remote_o && !kbd_lock_i;
  assign local_key_enable_o = (rl_state == RL_REMOTE);

  //////////////////////////////////////////////////////////////////////////////

  // Device clear, universal or selected.
  assign dev_clear = cmd_take &&
    ((cmd == `GDI_CMD_DCL) || (cmd == `GDI_CMD_SDC && lacs));

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      clear_o <= '0;
    end else if (ce_i) begin
      clear_o <= {4{dev_clear}};
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Triggering: arm, disable on clear, fire once on an addressed trigger.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      trig_armed <= 1'b0;
      trig_off <= 1'b0;
      trigger_o <= 1'b0;
      sub_resume_o <= 1'b0;
    end else if (ce_i) begin
      trigger_o <= 1'b0;
      sub_resume_o <= 1'b0;
      if (dev_clear) begin
        trig_off <= 1'b1;
      end else if (instr_cmd_i) begin
        trig_off <= 1'b0;
      end
      if (single_trigger_command_i && !trig_off) begin
        trigger_o <= 1'b1;
      end
      if (cmd_take && cmd == `GDI_CMD_GET && lacs) begin
        if (sub_paused_i) begin
          sub_resume_o <= 1'b1;
        end else if (trig_armed && !trig_off) begin
          trigger_o <= 1'b1;
          trig_armed <= 1'b0;
        end
      end
      // Arming comes last so that an arm in the trigger cycle is kept.
      if (trigger_arm_command_i) begin
        trig_armed <= 1'b1;
      end
    end
  end

  assign trigger_enable_o = !trig_off;

  //////////////////////////////////////////////////////////////////////////////

  // Status byte: sticky event bits, live ready bit, request summary bit.
  always_comb begin
    cause = status_cause_i;
    cause[`GDI_SB_READY] = ready_i && !sub_running_i;
    cause[`GDI_SB_RQS] = 1'b0;
  end

  // The request bit is rebuilt from the surviving bits, so a clear cannot strand it.

  always_comb begin
    next_stb = stb;
    if (dev_clear) begin
      next_stb = stb & cause & `GDI_SB_DCL_KEEP;
    end else if (sp_sent && stb[`GDI_SB_RQS]) begin
      next_stb = stb & cause;
    end
    next_stb = next_stb | status_event_i;
    next_stb[`GDI_SB_ERROR] = next_stb[`GDI_SB_ERROR] | cause[`GDI_SB_ERROR];
    next_stb[`GDI_SB_RQS] = next_stb[`GDI_SB_RQS] |
      (|{next_stb[`GDI_SB_DATA], next_stb[`GDI_SB_ERROR], next_stb[3:0]});
    next_stb[`GDI_SB_READY] = cause[`GDI_SB_READY];
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stb <= `GDI_SB_RESET;
    end else if (ce_i) begin
      stb <= next_stb;
    end
  end

  assign serial_poll_status_byte_o = stb;
  assign srq_n_o = 1'b0;
  assign srq_n_oe_o = stb[`GDI_SB_RQS];

  // Status query goes through the processor, so it always reads busy.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      status_replace_o <= 1'b0;
      status_replace_data_o <= '0;
    end else if (ce_i) begin
      status_replace_o <= status_byte_query_i;
      if (status_byte_query_i) begin
        status_replace_data_o <= stb & ~(8'h01 << `GDI_SB_READY);
      end
    end
  end

endmodule : gdi_device_port

// [core/gdi_src_hs.sv]
// Source handshake engine that places one byte on the bus per three-wire cycle.
`timescale 1ns/10ps
`include "gdi_defines.svh"

module gdi_src_hs import gdi_pkg::*; #(
  parameter int SETTLE_CYC = `GDI_SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic enable_i,
  input wire logic valid_i,
  input wire gdi_byte_s byte_i,
  input wire logic nrfd_as_i,
  input wire logic ndac_as_i,
  output logic taken_o,
  output logic dav_as_o,
  output logic drive_o,
  output gdi_byte_s byte_o
);

  generate
    if (SETTLE_CYC < 1) begin : g_bad
      $error("gdi_src_hs: SETTLE_CYC must be at least one cycle.");
    end
  endgenerate

  localparam int CW = $clog2(SETTLE_CYC + 1);

  gdi_sh_e state;
  logic [CW-1:0] settle;

  //////////////////////////////////////////////////////////////////////////////

  // Data is driven, allowed to settle, then DAV is held until all accept.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= SH_IDLE;
      settle <= '0;
      byte_o <= '0;
    end else if (ce_i) begin
      if (!enable_i) begin
        state <= SH_IDLE;
      end else begin
        unique case (state)
          SH_IDLE: begin
            if (valid_i && !nrfd_as_i) begin
              byte_o <= byte_i;
              settle <= CW'(SETTLE_CYC - 1);
              state <= SH_SETTLE;
            end
          end
          SH_SETTLE: begin
            if (settle == '0) begin
              state <= SH_DAV;
            end else begin
              settle <= settle - 1'b1;
            end
          end
          SH_DAV: begin
            if (!ndac_as_i) begin
              state <= SH_DONE;
            end
          end
          SH_DONE: begin
            if (ndac_as_i) begin
              state <= SH_IDLE;
            end
          end
        endcase
      end
    end
  end

  assign dav_as_o = enable_i && (state == SH_DAV);
  assign drive_o = enable_i && (state != SH_IDLE);
  assign taken_o = ce_i && enable_i && (state == SH_DAV) && !ndac_as_i;

endmodule : gdi_src_hs

// [inc/gdi_defines.svh]
// Constants for the instrument bus interface block.
`ifndef GDI_DEFINES_SVH
`define GDI_DEFINES_SVH

`define GDI_CLK_MHZ 250
`define GDI_SETTLE_NS 500
`define GDI_SETTLE_CYC ((`GDI_SETTLE_NS * `GDI_CLK_MHZ + 999) / 1000)

`define GDI_CMD_GTL 7'h01
`define GDI_CMD_SDC 7'h04
`define GDI_CMD_GET 7'h08
`define GDI_CMD_LLO 7'h11
`define GDI_CMD_DCL 7'h14
`define GDI_CMD_SPE 7'h18
`define GDI_CMD_SPD 7'h19
`define GDI_CMD_UNL 7'h3F
`define GDI_GRP_LISTEN 2'b01
`define GDI_GRP_TALK 2'b10

`define GDI_SB_SUB_DONE 0
`define GDI_SB_LIMIT 1
`define GDI_SB_USER_SRQ 2
`define GDI_SB_PWR_ON 3
`define GDI_SB_READY 4
`define GDI_SB_ERROR 5
`define GDI_SB_RQS 6
`define GDI_SB_DATA 7
`define GDI_SB_RESET 8'h00
`define GDI_SB_DCL_KEEP 8'h70

`endif

// [inc/gdi_pkg.sv]
// Types shared by the instrument bus interface block.
package gdi_pkg;

  typedef enum logic [1:0] {
    RL_LOCAL,
    RL_REMOTE,
    RL_LOCAL_LOCK,
    RL_REMOTE_LOCK
  } gdi_rl_e;

  typedef enum logic [0:0] {
    AH_WAIT,
    AH_HOLD
  } gdi_ah_e;

  typedef enum logic [1:0] {
    SH_IDLE,
    SH_SETTLE,
    SH_DAV,
    SH_DONE
  } gdi_sh_e;

  typedef struct packed {
    logic [7:0] data;
    logic eoi;
  } gdi_byte_s;

  typedef struct packed {
    logic out_flush;
    logic in_flush;
    logic sub_abort;
    logic display_blank;
  } gdi_clr_s;

endpackage : gdi_pkg
